// *** hw/dbpac_pkg.sv ***
/*
 * dbpac_pkg: register numbers, codes, dial characters and timing figures
 * for the data link configuration and auto-dial connect block.
 * assumes a 100 MHz core clock; times are kept in microseconds.
 */
package dbpac_pkg;
   // ==========================================================
   // register numbers on the control/status register port
   localparam logic [7:0] REG_CONN_CMD_STATE = 8'h0c; // connection_command_and_state
   localparam logic [7:0] REG_CONN_TIMEOUT = 8'h10;   // connect timeout, seconds
   localparam logic [7:0] REG_TX_BLK_LIMIT = 8'h18;   // transmit_block_length_limit
   localparam logic [7:0] REG_LINK_PARITY = 8'h24;    // link_parity_select
   // ==========================================================
   // reset values
   localparam logic [7:0] RST_TX_BLK_LIMIT = 8'h00;
   localparam logic [7:0] RST_LINK_PARITY = 8'h00;
   localparam logic [7:0] RST_CONN_TIMEOUT = 8'h00;
   // ==========================================================
   // control block codes, status codes of the connection register and link parity codes
   localparam logic [7:0] CMD_START_CONNECT = 8'h01;
   localparam logic [7:0] CMD_START_DIAL = 8'h02;
   localparam logic [7:0] STS_IDLE = 8'h00;
   localparam logic [7:0] STS_TRYING = 8'h01;
   localparam logic [7:0] STS_DIALING = 8'h02;
   localparam logic [7:0] STS_CONNECTED = 8'h03;
   localparam logic [7:0] STS_SUSPENDED = 8'h04;
   localparam logic [7:0] PAR_NONE = 8'h00;
   localparam logic [7:0] PAR_ODD = 8'h01;
   // ==========================================================
   // dial string characters and sizes
   localparam logic [7:0] CH_FAST = 8'h3e;
   localparam logic [7:0] CH_DELAY = 8'h40;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_NINE = 8'h39;
   localparam logic [8:0] DIAL_MAX = 9'h1f4;  // 500 characters
   localparam logic [9:0] BLK_MAX = 10'h200;  // 512 characters
   localparam logic [3:0] PULSES_ZERO = 4'ha; // digit zero gives ten
   // ==========================================================
   // timing, microseconds, and derived cycle counts
   localparam int CLK_MHZ = 100;
   localparam int T_OFFLINE_US = 2000000;
   localparam int T_SETTLE_US = 500000;
   localparam int T_DELAY_US = 1000000;
   localparam int T_SLOW_CLICK_US = 60000;
   localparam int T_SLOW_GAP_US = 40000;
   localparam int T_SLOW_NUM_US = 700000;
   localparam int T_FAST_CLICK_US = 32500;
   localparam int T_FAST_GAP_US = 17500;
   localparam int T_FAST_NUM_US = 300000;
   localparam int CYC_OFFLINE = T_OFFLINE_US * CLK_MHZ;
   localparam int CYC_SETTLE = T_SETTLE_US * CLK_MHZ;
   localparam int CYC_DELAY = T_DELAY_US * CLK_MHZ;
   localparam int CYC_SLOW_CLICK = T_SLOW_CLICK_US * CLK_MHZ;
   localparam int CYC_SLOW_GAP = T_SLOW_GAP_US * CLK_MHZ;
   localparam int CYC_SLOW_NUM = T_SLOW_NUM_US * CLK_MHZ;
   localparam int CYC_FAST_CLICK = T_FAST_CLICK_US * CLK_MHZ;
   localparam int CYC_FAST_GAP = T_FAST_GAP_US * CLK_MHZ;
   localparam int CYC_FAST_NUM = T_FAST_NUM_US * CLK_MHZ;
endpackage

// *** hw/dbpac_top.sv ***
/*
 * dbpac_top: data link configuration registers, outbound queue handling,
 * pulse auto-dialer and line connection sequencer.
 * assumes the host library feeds control blocks and output data in queue
 * order on the outbound port, and modem pins arrive asynchronously.
 */
// Functional notes
// - block size register zero caps outbound blocks at 512 characters.
// - nonzero block size limits blocks to twice the programmed value.
// - parity register takes only 0 none or 1 odd.
// - registers 25 to 35 and 37 upward have no effect.
// - fast dial timing only when first string character is fast marker.
// - each delay character pauses dialing one second.
// - characters other than digits and markers are skipped silently.
// - dial string holds up to 500 characters.
// - control block 2 routes the following string to the dialer only.
// - control block 1 issues start-connection to the modem.
// - modem off line two seconds, reconnect, wait 500 ms, dial in order.
// - slow dialing: 60 ms clicks, 40 ms gaps, 700 ms between digits.
// - fast dialing: 32.5 ms clicks, 17.5 ms gaps, 300 ms between digits.
// - digits one to nine give that many pulses, zero gives ten.
// - digit gap runs from last click end to next first click.
// - without auto-dial, start-connection connects the line directly.
// - status 12 shows 1 trying, 2 dialing, 3 connected.
// - no line ready within timeout drops line, suspends, flags error.
`timescale 1ns/1ps
module dbpac_top import dbpac_pkg::*; #(
   parameter int unsigned P_CYC_OFFLINE = CYC_OFFLINE,
   parameter int unsigned P_CYC_SETTLE = CYC_SETTLE,
   parameter int unsigned P_CYC_DELAY = CYC_DELAY,
   parameter int unsigned P_CYC_SLOW_CLICK = CYC_SLOW_CLICK,
   parameter int unsigned P_CYC_SLOW_GAP = CYC_SLOW_GAP,
   parameter int unsigned P_CYC_SLOW_NUM = CYC_SLOW_NUM,
   parameter int unsigned P_CYC_FAST_CLICK = CYC_FAST_CLICK,
   parameter int unsigned P_CYC_FAST_GAP = CYC_FAST_GAP,
   parameter int unsigned P_CYC_FAST_NUM = CYC_FAST_NUM
) (
   input wire logic I_CLK,
   input wire logic I_RSTN,
   input wire logic I_CE,
   input wire logic I_CTRL_WR,
   input wire logic I_STAT_RD,
   input wire logic [7:0] I_REG_NUM,
   input wire logic [7:0] I_WR_DATA,
   output logic [7:0] O_RD_DATA,
   output logic O_RD_VALID,
   input wire logic I_OB_VALID,
   input wire logic I_OB_CTRL,
   input wire logic I_OB_LAST,
   input wire logic [7:0] I_OB_DATA,
   output logic O_OB_READY,
   output logic [7:0] O_TX_DATA,
   output logic O_TX_PAR,
   output logic O_TX_VALID,
   output logic O_TX_EOB,
   output logic O_PARITY_ODD,
   input wire logic I_AUTODIAL_EN,
   input wire logic I_LINE_READY,
   output logic O_LINE_CONNECT,
   output logic O_DIAL_PULSE,
   output logic O_CONN_ERR
);

   // ==========================================================
   // types and state
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_OFFLINE = 4'b0001,
      ST_SETTLE = 4'b0010,
      ST_FETCH = 4'b0011,
      ST_NUM_GAP = 4'b0100,
      ST_PULSE_ON = 4'b0101,
      ST_PULSE_OFF = 4'b0110,
      ST_DELAY = 4'b0111,
      ST_WAIT_READY = 4'b1000,
      ST_CONNECTED = 4'b1001,
      ST_SUSPENDED = 4'b1010
   } dbpac_state_e;

   typedef struct packed {
      dbpac_state_e st;
      logic [31:0] tmr;
      logic [7:0] secs;
      logic [3:0] pulses;
      logic gap_pend;
      logic fast;
      logic capture;
      logic [8:0] wr_ptr;
      logic [8:0] rd_ptr;
      logic [7:0] blk_lim;
      logic par_odd;
      logic [7:0] tout;
      logic [9:0] tx_cnt;
      logic [2:0] s_ad;
      logic ad_f;
      logic [2:0] s_rdy;
      logic rdy_f;
      logic [7:0] rd_data;
      logic rd_valid;
      logic [7:0] tx_data;
      logic tx_par;
      logic tx_valid;
      logic tx_eob;
      logic line_conn;
      logic pulse;
      logic conn_err;
      logic ob_ready;
   } dbpac_state_s;

   dbpac_state_s r_ff;
   dbpac_state_s nxt_r;
   logic [7:0] dial_mem [0:499];
   logic [7:0] dial_ch;
   logic ob_take;
   logic mem_wr;

   // ==========================================================
   // helpers
   // block limit: zero means 512, else twice the value
   function automatic logic [9:0] blk_limit(input logic [7:0] v);
      blk_limit = (v == 8'h00) ? BLK_MAX : {1'b0, v, 1'b0};
   endfunction

   // load value for a wait of n cycles, never below one cycle
   function automatic logic [31:0] ld(input int unsigned n);
      ld = (n > 1) ? 32'(n - 1) : 32'h0000_0000;
   endfunction

   function automatic dbpac_state_s mux_status(input dbpac_state_s s, input logic [7:0] sts);
      mux_status = s;
      mux_status.rd_data = sts;
   endfunction

   assign ob_take = I_OB_VALID & r_ff.ob_ready;
   assign dial_ch = dial_mem[r_ff.rd_ptr];
   assign mem_wr = I_CE & ob_take & ~I_OB_CTRL & r_ff.capture & (r_ff.wr_ptr < DIAL_MAX);

   // dial string store, written only while capturing
   always_ff @(posedge I_CLK) begin
      if (mem_wr) begin
         dial_mem[r_ff.wr_ptr] <= I_OB_DATA;
      end
   end

   // ==========================================================
   // next-state logic
   always_comb begin
      nxt_r = r_ff;
      nxt_r.rd_valid = 1'b0;
      nxt_r.tx_valid = 1'b0;
      nxt_r.tx_eob = 1'b0;
      // pin synchronisers, change taken when stages two and three agree
      nxt_r.s_ad = {r_ff.s_ad[1:0], I_AUTODIAL_EN};
      nxt_r.s_rdy = {r_ff.s_rdy[1:0], I_LINE_READY};
      if (r_ff.s_ad[1] == r_ff.s_ad[2]) begin
         nxt_r.ad_f = r_ff.s_ad[2];
      end
      if (r_ff.s_rdy[1] == r_ff.s_rdy[2]) begin
         nxt_r.rdy_f = r_ff.s_rdy[2];
      end

      // control register writes
      if (I_CTRL_WR) begin
         case (I_REG_NUM)
            REG_TX_BLK_LIMIT: nxt_r.blk_lim = I_WR_DATA;
            REG_LINK_PARITY: begin
               if (I_WR_DATA == PAR_NONE || I_WR_DATA == PAR_ODD) begin
                  nxt_r.par_odd = I_WR_DATA[0];
               end
            end
            REG_CONN_TIMEOUT: nxt_r.tout = I_WR_DATA;
            default: nxt_r.tout = r_ff.tout;
         endcase
      end

      // status register reads
      if (I_STAT_RD) begin
         nxt_r.rd_valid = 1'b1;
         case (I_REG_NUM)
            REG_CONN_CMD_STATE: begin
               case (r_ff.st)
                  ST_IDLE: nxt_r = mux_status(nxt_r, STS_IDLE);
                  ST_FETCH, ST_NUM_GAP, ST_PULSE_ON, ST_PULSE_OFF, ST_DELAY:
                     nxt_r = mux_status(nxt_r, STS_DIALING);
                  ST_CONNECTED: nxt_r = mux_status(nxt_r, STS_CONNECTED);
                  ST_SUSPENDED: nxt_r = mux_status(nxt_r, STS_SUSPENDED);
                  default: nxt_r = mux_status(nxt_r, STS_TRYING);
               endcase
            end
            REG_CONN_TIMEOUT: nxt_r.rd_data = r_ff.tout;
            REG_TX_BLK_LIMIT: nxt_r.rd_data = r_ff.blk_lim;
            REG_LINK_PARITY: nxt_r.rd_data = {7'h00, r_ff.par_odd};
            default: nxt_r.rd_data = 8'h00;
         endcase
      end

      // outbound queue, one item at a time in arrival order
      if (ob_take) begin
         if (I_OB_CTRL) begin
            if (I_OB_DATA == CMD_START_DIAL) begin
               nxt_r.capture = 1'b1;
               nxt_r.wr_ptr = 9'h000;
               nxt_r.fast = 1'b0;
            end else if (I_OB_DATA == CMD_START_CONNECT && r_ff.st != ST_SUSPENDED) begin
               nxt_r.capture = 1'b0;
               nxt_r.conn_err = 1'b0;
               nxt_r.secs = 8'h00;
               if (r_ff.ad_f) begin
                  nxt_r.line_conn = 1'b0;
                  nxt_r.st = ST_OFFLINE;
                  nxt_r.tmr = ld(P_CYC_OFFLINE);
               end else begin
                  nxt_r.line_conn = 1'b1;
                  nxt_r.st = ST_WAIT_READY;
                  nxt_r.tmr = ld(P_CYC_DELAY);
               end
            end
         end else if (r_ff.capture) begin
            if (r_ff.wr_ptr < DIAL_MAX) begin
               nxt_r.wr_ptr = r_ff.wr_ptr + 9'h001;
               if (r_ff.wr_ptr == 9'h000 && I_OB_DATA == CH_FAST) begin
                  nxt_r.fast = 1'b1;
               end
            end
            if (I_OB_LAST) begin
               nxt_r.capture = 1'b0;
            end
         end else if (r_ff.st == ST_CONNECTED) begin
            nxt_r.tx_valid = 1'b1;
            nxt_r.tx_data = I_OB_DATA;
            nxt_r.tx_par = r_ff.par_odd & ~(^I_OB_DATA);
            if (r_ff.tx_cnt + 10'h001 >= blk_limit(r_ff.blk_lim) || I_OB_LAST) begin
               nxt_r.tx_eob = 1'b1;
               nxt_r.tx_cnt = 10'h000;
            end else begin
               nxt_r.tx_cnt = r_ff.tx_cnt + 10'h001;
            end
         end
      end

      // connection and dial sequencer
      case (r_ff.st)
         ST_OFFLINE: begin
            if (r_ff.tmr == 32'h0000_0000) begin
               nxt_r.line_conn = 1'b1;
               nxt_r.st = ST_SETTLE;
               nxt_r.tmr = ld(P_CYC_SETTLE);
            end else begin
               nxt_r.tmr = r_ff.tmr - 32'h0000_0001;
            end
         end
         ST_SETTLE: begin
            if (r_ff.tmr == 32'h0000_0000) begin
               nxt_r.st = ST_FETCH;
               nxt_r.rd_ptr = 9'h000;
               nxt_r.gap_pend = 1'b0;
            end else begin
               nxt_r.tmr = r_ff.tmr - 32'h0000_0001;
            end
         end
         ST_FETCH: begin
            if (r_ff.rd_ptr >= r_ff.wr_ptr) begin
               nxt_r.st = ST_WAIT_READY;
               nxt_r.tmr = ld(P_CYC_DELAY);
            end else begin
               nxt_r.rd_ptr = r_ff.rd_ptr + 9'h001; // one at a time, in order
               if (dial_ch == CH_DELAY) begin
                  nxt_r.st = ST_DELAY;
                  nxt_r.tmr = ld(P_CYC_DELAY);
               end else if (dial_ch >= CH_ZERO && dial_ch <= CH_NINE) begin
                  nxt_r.pulses = (dial_ch == CH_ZERO) ? PULSES_ZERO : dial_ch[3:0];
                  if (r_ff.gap_pend) begin
                     nxt_r.st = ST_NUM_GAP;
                     nxt_r.tmr = r_ff.fast ? ld(P_CYC_FAST_NUM) : ld(P_CYC_SLOW_NUM);
                  end else begin
                     nxt_r.st = ST_PULSE_ON;
                     nxt_r.pulse = 1'b1;
                     nxt_r.tmr = r_ff.fast ? ld(P_CYC_FAST_CLICK) : ld(P_CYC_SLOW_CLICK);
                  end
               end
               // anything else, the fast marker included, is skipped
            end
         end
         ST_NUM_GAP, ST_PULSE_OFF: begin
            if (r_ff.tmr == 32'h0000_0000) begin
               nxt_r.st = ST_PULSE_ON;
               nxt_r.pulse = 1'b1;
               nxt_r.tmr = r_ff.fast ? ld(P_CYC_FAST_CLICK) : ld(P_CYC_SLOW_CLICK);
            end else begin
               nxt_r.tmr = r_ff.tmr - 32'h0000_0001;
            end
         end
         ST_PULSE_ON: begin
            if (r_ff.tmr == 32'h0000_0000) begin
               nxt_r.pulse = 1'b0;
               nxt_r.pulses = r_ff.pulses - 4'h1;
               if (r_ff.pulses == 4'h1) begin
                  nxt_r.gap_pend = 1'b1;
                  nxt_r.st = ST_FETCH;
               end else begin
                  nxt_r.st = ST_PULSE_OFF;
                  nxt_r.tmr = r_ff.fast ? ld(P_CYC_FAST_GAP) : ld(P_CYC_SLOW_GAP);
               end
            end else begin
               nxt_r.tmr = r_ff.tmr - 32'h0000_0001;
            end
         end
         ST_DELAY: begin
            if (r_ff.tmr == 32'h0000_0000) begin
               nxt_r.st = ST_FETCH;
            end else begin
               nxt_r.tmr = r_ff.tmr - 32'h0000_0001;
            end
         end
         ST_WAIT_READY: begin
            if (r_ff.rdy_f) begin
               nxt_r.st = ST_CONNECTED;
               nxt_r.tx_cnt = 10'h000;
            end else if (r_ff.tout != 8'h00) begin
               if (r_ff.tmr == 32'h0000_0000) begin
                  nxt_r.tmr = ld(P_CYC_DELAY);
                  nxt_r.secs = r_ff.secs + 8'h01;
                  if (r_ff.secs + 8'h01 >= r_ff.tout) begin
                     nxt_r.line_conn = 1'b0;
                     nxt_r.conn_err = 1'b1;
                     nxt_r.st = ST_SUSPENDED;
                  end
               end else begin
                  nxt_r.tmr = r_ff.tmr - 32'h0000_0001;
               end
            end
         end
         default: nxt_r.st = nxt_r.st;
      endcase

      // queue accepts only outside the connect sequence, keeping order
      case (nxt_r.st)
         ST_IDLE, ST_CONNECTED, ST_SUSPENDED: nxt_r.ob_ready = 1'b1;
         default: nxt_r.ob_ready = 1'b0;
      endcase
   end

   // ==========================================================
   // state register, frozen while the clock enable is low
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         r_ff <= '0;
      end else if (I_CE) begin
         r_ff <= nxt_r;
      end
   end

   assign O_RD_DATA = r_ff.rd_data;
   assign O_RD_VALID = r_ff.rd_valid;
   assign O_OB_READY = r_ff.ob_ready;
   assign O_TX_DATA = r_ff.tx_data;
   assign O_TX_PAR = r_ff.tx_par;
   assign O_TX_VALID = r_ff.tx_valid;
   assign O_TX_EOB = r_ff.tx_eob;
   assign O_PARITY_ODD = r_ff.par_odd;
   assign O_LINE_CONNECT = r_ff.line_conn;
   assign O_DIAL_PULSE = r_ff.pulse;
   assign O_CONN_ERR = r_ff.conn_err;
endmodule // dbpac_top

// *** sim/dbpac_modem_model.sv ***
/*
 * dbpac_modem_model: pulse dial modem and line seen from the block.
 * assumes connect and click outputs on the bench clock.
 */
`timescale 1ns/1ps
module dbpac_modem_model #(
   parameter int P_ANSWER = 100
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_connect,
   input wire logic i_pulse,
   output logic o_ready
);
   int quiet;
   int clicks;
   int hi;
   int hi_len;
   int digits[$];
   logic prev;
   // ==========================================================
   // count clicks, close a digit after a quiet spell, answer late
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         quiet <= 0;
         clicks <= 0;
         hi <= 0;
         prev <= 1'b0;
         o_ready <= 1'b0;
         digits.delete();
      end else begin
         prev <= i_pulse;
         hi <= i_pulse ? hi + 1 : 0;
         if (!i_pulse && prev) hi_len <= hi;
         if (i_pulse && !prev) clicks <= clicks + 1;
         quiet <= (i_pulse || !i_connect) ? 0 : quiet + 1;
         if (quiet == 8 && clicks > 0) begin
            digits.push_back(clicks % 10);
            clicks <= 0;
         end
         o_ready <= i_connect && quiet >= P_ANSWER;
      end
   end
endmodule // dbpac_modem_model

// *** sim/dbpac_top_properties.sv ***
/*
 * dbpac_top_checker: port level properties of the link block.
 * assumes I_CE held high while clicks are timed.
 */
`timescale 1ns/1ps
module dbpac_top_checker import dbpac_pkg::*; #(
   parameter int unsigned P_CYC_SLOW_CLICK = CYC_SLOW_CLICK,
   parameter int unsigned P_CYC_FAST_CLICK = CYC_FAST_CLICK
) (
   input wire logic I_CLK,
   input wire logic I_RSTN,
   input wire logic I_CE,
   input wire logic I_CTRL_WR,
   input wire logic I_STAT_RD,
   input wire logic [7:0] I_REG_NUM,
   input wire logic [7:0] I_WR_DATA,
   input wire logic [7:0] O_RD_DATA,
   input wire logic O_RD_VALID,
   input wire logic I_OB_VALID,
   input wire logic I_OB_CTRL,
   input wire logic [7:0] I_OB_DATA,
   input wire logic O_OB_READY,
   input wire logic [7:0] O_TX_DATA,
   input wire logic O_TX_PAR,
   input wire logic O_TX_VALID,
   input wire logic O_TX_EOB,
   input wire logic O_PARITY_ODD,
   input wire logic O_LINE_CONNECT,
   input wire logic O_DIAL_PULSE
);
   logic [7:0] blk_ff;
   logic [10:0] txn_ff;
   int unsigned hi_ff;
   logic wr_ok;
   logic [10:0] lim;
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RSTN);
   assign wr_ok = I_CE && I_CTRL_WR;
   assign lim = (blk_ff == 8'h00) ? 11'h200 : {2'h0, blk_ff, 1'b0};
   // ==========================================================
   // shadow block limit, chars so far in block, click length
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         blk_ff <= 8'h00;
         txn_ff <= 11'h000;
         hi_ff <= 0;
      end else begin
         if (wr_ok && I_REG_NUM == REG_TX_BLK_LIMIT) blk_ff <= I_WR_DATA;
         if (O_TX_VALID) txn_ff <= O_TX_EOB ? 11'h000 : txn_ff + 11'h001;
         hi_ff <= O_DIAL_PULSE ? hi_ff + 1 : 0;
      end
   end
   // ==========================================================
   // properties
   property p_rd_answer;
      I_CE && I_STAT_RD |=> O_RD_VALID;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_rd_status;
      I_CE && I_STAT_RD && I_REG_NUM == REG_CONN_CMD_STATE |=> O_RD_DATA <= STS_SUSPENDED;
   endproperty
   a_rd_status: assert property (p_rd_status) else $error("bad status code");
   property p_par_set;
      wr_ok && I_REG_NUM == REG_LINK_PARITY && I_WR_DATA <= 8'h01
      |=> O_PARITY_ODD == $past(I_WR_DATA[0]);
   endproperty
   a_par_set: assert property (p_par_set) else $error("parity not taken");
   property p_par_keep;
      wr_ok && (I_REG_NUM != REG_LINK_PARITY || I_WR_DATA > 8'h01) |=> $stable(O_PARITY_ODD);
   endproperty
   a_par_keep: assert property (p_par_keep) else $error("parity moved");
   property p_tx_par;
      O_TX_VALID |-> O_TX_PAR == (O_PARITY_ODD & ~^O_TX_DATA);
   endproperty
   a_tx_par: assert property (p_tx_par) else $error("parity bit wrong");
   property p_blk_len;
      O_TX_VALID |-> (txn_ff + 11'h001 < lim) || (txn_ff + 11'h001 == lim && O_TX_EOB);
   endproperty
   a_blk_len: assert property (p_blk_len) else $error("block too long");
   property p_click_len;
      $fell(O_DIAL_PULSE) |-> hi_ff == P_CYC_SLOW_CLICK || hi_ff == P_CYC_FAST_CLICK;
   endproperty
   a_click_len: assert property (p_click_len) else $error("click length");
   property p_pulse_line;
      O_DIAL_PULSE |-> O_LINE_CONNECT;
   endproperty
   a_pulse_line: assert property (p_pulse_line) else $error("click off line");
   property p_conn_hold;
      I_CE && I_OB_VALID && O_OB_READY && I_OB_CTRL && I_OB_DATA == CMD_START_CONNECT
      |=> !O_OB_READY;
   endproperty
   a_conn_hold: assert property (p_conn_hold) else $error("queue not held");
endmodule // dbpac_top_checker
bind dbpac_top dbpac_top_checker #(.P_CYC_SLOW_CLICK(P_CYC_SLOW_CLICK),
   .P_CYC_FAST_CLICK(P_CYC_FAST_CLICK)) dbpac_top_checker_inst (.I_CLK(I_CLK),
   .I_RSTN(I_RSTN), .I_CE(I_CE), .I_CTRL_WR(I_CTRL_WR), .I_STAT_RD(I_STAT_RD),
   .I_REG_NUM(I_REG_NUM), .I_WR_DATA(I_WR_DATA), .O_RD_DATA(O_RD_DATA),
   .O_RD_VALID(O_RD_VALID), .I_OB_VALID(I_OB_VALID), .I_OB_CTRL(I_OB_CTRL),
   .I_OB_DATA(I_OB_DATA), .O_OB_READY(O_OB_READY), .O_TX_DATA(O_TX_DATA),
   .O_TX_PAR(O_TX_PAR), .O_TX_VALID(O_TX_VALID), .O_TX_EOB(O_TX_EOB),
   .O_PARITY_ODD(O_PARITY_ODD), .O_LINE_CONNECT(O_LINE_CONNECT),
   .O_DIAL_PULSE(O_DIAL_PULSE));

// *** sim/dbpac_tb.sv ***
/*
 * testbench: registers, direct connect, block cutting and pulse dialing.
 * assumes shortened dial timing parameters and the modem model on the pins.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module testbench import dbpac_pkg::*;;
   localparam int SC = 6;
   localparam int FC = 3, OC = 40, DC = 30;
   int n_mismatch = 0;
   int cmp_count = 0;
   logic [31:0] seed = 32'h5e7d53ca;
   logic [9:0] txq[$];
   logic [9:0] exp_tx;
   logic clk = 1'b0, rstn = 1'b0, ctrl_wr = 1'b0, stat_rd = 1'b0, ob_valid = 1'b0;
   logic ob_ctrl = 1'b0, ob_last = 1'b0, ad_en = 1'b0, ce = 1'b1, conn_err;
   logic [7:0] reg_num = 8'h00, wr_data = 8'h00, ob_data = 8'h00, rd_data, tx_data;
   logic rd_valid, ob_ready, tx_par, tx_valid, tx_eob, par_odd, line_rdy, line_con, pulse;
   always #5 clk = ~clk;
   dbpac_top #(.P_CYC_OFFLINE(OC), .P_CYC_SETTLE(20), .P_CYC_DELAY(DC),
      .P_CYC_SLOW_CLICK(SC), .P_CYC_SLOW_GAP(4), .P_CYC_SLOW_NUM(20),
      .P_CYC_FAST_CLICK(FC), .P_CYC_FAST_GAP(2), .P_CYC_FAST_NUM(10)) dbpac_top_inst (
      .I_CLK(clk), .I_RSTN(rstn), .I_CE(ce), .I_CTRL_WR(ctrl_wr), .I_STAT_RD(stat_rd),
      .I_REG_NUM(reg_num), .I_WR_DATA(wr_data), .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid),
      .I_OB_VALID(ob_valid), .I_OB_CTRL(ob_ctrl), .I_OB_LAST(ob_last), .I_OB_DATA(ob_data),
      .O_OB_READY(ob_ready), .O_TX_DATA(tx_data), .O_TX_PAR(tx_par), .O_TX_VALID(tx_valid),
      .O_TX_EOB(tx_eob), .O_PARITY_ODD(par_odd), .I_AUTODIAL_EN(ad_en),
      .I_LINE_READY(line_rdy), .O_LINE_CONNECT(line_con), .O_DIAL_PULSE(pulse),
      .O_CONN_ERR(conn_err));
   dbpac_modem_model dbpac_modem_model_inst (.i_clk(clk), .i_rstn(rstn),
      .i_connect(line_con), .i_pulse(pulse), .o_ready(line_rdy));
   // ==========================================================
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic wr(input logic [7:0] r, input logic [7:0] d);
      ctrl_wr <= 1'b1;
      reg_num <= r;
      wr_data <= d;
      @(posedge clk);
      ctrl_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] r, output logic [7:0] v);
      stat_rd <= 1'b1;
      reg_num <= r;
      @(posedge clk);
      stat_rd <= 1'b0;
      @(posedge clk);
      `CHK("rd_valid", 1'b1, rd_valid)
      v = rd_data;
   endtask
   task automatic push(input logic c, input logic l, input logic [7:0] d);
      ob_valid <= 1'b1;
      ob_ctrl <= c;
      ob_last <= l;
      ob_data <= d;
      do @(posedge clk); while (ob_ready !== 1'b1);
   endtask
   task automatic ob_idle();
      ob_valid <= 1'b0;
      @(posedge clk);
   endtask
   task automatic do_reset();
      rstn <= 1'b0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
   endtask
   task automatic poll(output logic [7:0] seen);
      logic [7:0] v;
      seen = 8'h00;
      for (int i = 0; i < 1500 && v !== STS_CONNECTED; i++) begin
         rd(REG_CONN_CMD_STATE, v);
         seen[v[2:0]] = 1'b1;
      end
      `CHK("status", STS_CONNECTED, v)
   endtask
   task automatic blk(input int n, input int lim, input logic po);
      int k;
      logic [7:0] d;
      k = 0;
      for (int i = 1; i <= n; i++) begin
         seed = xs(seed);
         d = seed[7:0];
         k++;
         txq.push_back({(k == lim) || (i == n), po & ~^d, d});
         if (k == lim) k = 0;
         push(1'b0, i == n, d);
      end
      ob_idle();
   endtask
   task automatic dial(input string s);
      int exp_d[$];
      logic [7:0] seen;
      do_reset();
      ad_en <= 1'b1;
      for (int i = 0; i < s.len(); i++) begin
         if (s[i] >= CH_ZERO && s[i] <= CH_NINE) exp_d.push_back(s[i] - CH_ZERO);
      end
      push(1'b1, 1'b0, CMD_START_DIAL);
      for (int i = 0; i < s.len(); i++) push(1'b0, i == s.len() - 1, s[i]);
      push(1'b1, 1'b0, CMD_START_CONNECT);
      ob_idle();
      poll(seen);
      `CHK("saw_dialing", 1'b1, seen[2])
      `CHK("n_digits", exp_d.size(), dbpac_modem_model_inst.digits.size())
      foreach (exp_d[i]) `CHK("digit", exp_d[i], dbpac_modem_model_inst.digits[i])
      `CHK("click", (s[0] == CH_FAST) ? FC : SC, dbpac_modem_model_inst.hi_len)
      $display("test dial %s done", s);
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ==========================================================
   // transmit monitor against the queued model
   always @(posedge clk) begin
      if (tx_valid === 1'b1) begin
         exp_tx = (txq.size() > 0) ? txq.pop_front() : 10'h3ff;
         `CHK("tx_char", exp_tx, {tx_eob, tx_par, tx_data})
      end
   end
   // ==========================================================
   // watchdog
   initial begin
      repeat (30000) @(posedge clk);
      n_mismatch++;
      test_done();
   end
   // ==========================================================
   // main sequence
   initial begin
      logic [7:0] v;
      logic [7:0] seen;
      logic [7:0] unused[4] = '{8'h19, 8'h23, 8'h25, 8'hc8};
      do_reset();
      rd(REG_TX_BLK_LIMIT, v);
      `CHK("blk_rst", RST_TX_BLK_LIMIT, v)
      rd(REG_LINK_PARITY, v);
      `CHK("par_rst", RST_LINK_PARITY, v)
      wr(REG_TX_BLK_LIMIT, 8'h82);
      rd(REG_TX_BLK_LIMIT, v);
      `CHK("blk", 8'h82, v)
      wr(REG_LINK_PARITY, PAR_ODD);
      wr(REG_LINK_PARITY, 8'h02);
      ce <= 1'b0;
      wr(REG_LINK_PARITY, PAR_NONE);
      ce <= 1'b1;
      rd(REG_LINK_PARITY, v);
      `CHK("par", PAR_ODD, v)
      foreach (unused[i]) begin
         wr(unused[i], 8'h5a);
         rd(unused[i], v);
         `CHK("unused", 8'h00, v)
      end
      $display("test registers done");
      push(1'b1, 1'b0, CMD_START_CONNECT);
      ob_idle();
      poll(seen);
      `CHK("saw_trying", 1'b1, seen[1])
      `CHK("line", 1'b1, line_con)
      $display("test direct connect done");
      ad_en <= 1'b1;
      wr(REG_TX_BLK_LIMIT, 8'h00);
      blk(515, 512, 1'b1);
      wr(REG_TX_BLK_LIMIT, 8'h03);
      wr(REG_LINK_PARITY, PAR_NONE);
      blk(13, 6, 1'b0);
      repeat (4) @(posedge clk);
      `CHK("tx_left", 0, txq.size())
      wr(REG_CONN_TIMEOUT, 8'h01);
      push(1'b1, 1'b0, CMD_START_CONNECT);
      ob_idle();
      repeat (4 * DC) @(posedge clk);
      `CHK("conn_err", 1'b1, conn_err)
      $display("test blocks, timeout done");
      dial("(2)0-9");
      dial(">1@ 5>");
      test_done();
   end
endmodule // testbench
